/* gre_defines.vh */
// Register offsets, descriptor field layout and reset values for the region graphics engine
`ifndef GRE_DEFINES_VH
`define GRE_DEFINES_VH
`define GRE_OFS_CTRL 8'h00
`define GRE_OFS_STAT 8'h04
`define GRE_OFS_ANCH 8'h08
`define GRE_OFS_TINV 8'h0c
`define GRE_CTRL_RST 1'b0
`define GRE_ANCH_RST 20'h00000
`define GRE_DESC_LAST 2'd3
`define GRE_W0_X 9:0
`define GRE_W0_Y 19:10
`define GRE_W0_H 29:20
`define GRE_W0_EOL 31
`define GRE_W1_W 9:0
`define GRE_W1_DEPTH 11:10
`define GRE_W1_CODED 12
`define GRE_W1_ZOOM 13
`define GRE_W1_TSEN 14
`define GRE_W1_TSV 20:15
`define GRE_W2_TOP 19:0
`define GRE_W2_TPL 31:20
`define GRE_W3_BOT 19:0
`define GRE_W3_TPH 27:20
`define GRE_TH_COLOUR_LOOKUP_TABLE 8:0
`define GRE_TH_MAP 15:9
`define GRE_CL_Y 7:0
`define GRE_CL_U 15:8
`define GRE_CL_V 23:16
`define GRE_CL_T 29:24
`define GRE_DEPTH_2 2'd0
`define GRE_DEPTH_4 2'd1
`define GRE_IDLE_Y 8'h10
`define GRE_IDLE_C 8'h80
`endif

/* gre_mem_model.sv */
// Behavioural memory partner answering the engine's word reads
`timescale 1ns/1ps
module gre_mem_model (
  input wire clk_in, // Clock
  input wire srst_in, // Reset
  input wire mem_req_in, // Read request
  input wire [19:0] mem_addr_in, // Word address
  input wire slow_in, // Stretch accept and data delays
  output reg mem_ack_out, // Request taken
  output reg mem_rvalid_out, // Data valid
  output reg [31:0] mem_rdata_out // Read data
);
  reg [31:0] mem [0:1023];
  reg [19:0] addr_reg;
  reg pend_reg;
  int wt;
  always @(posedge clk_in) begin
    mem_ack_out <= 1'b0;
    mem_rvalid_out <= 1'b0;
    // Idle data keeps toggling so stale words never pass for fresh ones
    mem_rdata_out <= ~mem_rdata_out;
    if (srst_in) begin
      pend_reg <= 1'b0;
      wt <= 0;
      mem_rdata_out <= 32'h0;
    end else if (pend_reg) begin
      if (wt != 0) wt <= wt - 1;
      else begin
        mem_rvalid_out <= 1'b1;
        mem_rdata_out <= mem[addr_reg[9:0]];
        pend_reg <= 1'b0;
      end
    end else if (mem_req_in && !mem_ack_out) begin
      if (wt < (slow_in ? 2 : 0)) wt <= wt + 1;
      else begin
        mem_ack_out <= 1'b1;
        addr_reg <= mem_addr_in;
        pend_reg <= 1'b1;
        wt <= slow_in ? 2 : 0;
      end
    end
  end
endmodule // gre_mem_model

/* gre_pixel_unpack.v */
// Bitmap word unpacker: direct 2/4/8 bit pixels or run-length entries
`timescale 1ns/1ps
`include "gre_defines.vh"
module gre_pixel_unpack (
  input wire clk_in, // Clock
  input wire srst_in, // Synchronous reset
  input wire start_in, // Drop current word at region start
  input wire [1:0] depth_in, // Pixel depth code
  input wire coded_in, // Run-length coded stream
  input wire [31:0] word_in, // Next bitmap word
  input wire word_valid_in, // Next word present
  input wire step_in, // Consume one pixel
  output wire word_take_out, // Next word taken this cycle
  output wire [7:0] code_out, // Current pixel code
  output wire code_valid_out // Current code is backed by data
);
  reg [31:0] cur_reg;
  reg cur_v_reg;
  reg [4:0] pos_reg;
  reg [7:0] run_reg;
  wire [31:0] sh = cur_reg >> pos_reg;
  wire [7:0] mask = (depth_in == `GRE_DEPTH_2) ? 8'h03 : (depth_in == `GRE_DEPTH_4) ? 8'h0f : 8'hff;
  wire [5:0] unit = coded_in ? 6'h10 : (depth_in == `GRE_DEPTH_2) ? 6'h02 :
                    (depth_in == `GRE_DEPTH_4) ? 6'h04 : 6'h08;
  wire last = (({1'b0, pos_reg} + unit) == 6'h20);
  // A run length of zero stands for 256 repeats; the wrap of the subtraction gives that
  wire adv = !coded_in || (run_reg == (sh[15:8] - 8'h01));
  assign word_take_out = word_valid_in && !start_in && (!cur_v_reg || (step_in && adv && last));
  assign code_out = cur_v_reg ? ((coded_in ? sh[7:0] : sh[7:0]) & mask) : 8'h00;
  assign code_valid_out = cur_v_reg;

  always @(posedge clk_in) begin
    if (srst_in || start_in) begin
      cur_reg <= 32'h00000000;
      cur_v_reg <= 1'b0;
      pos_reg <= 5'h00;
      run_reg <= 8'h00;
    end else if (word_take_out) begin
      cur_reg <= word_in;
      cur_v_reg <= 1'b1;
      pos_reg <= 5'h00;
      run_reg <= 8'h00;
    end else if (step_in && cur_v_reg) begin
      if (adv) begin
        run_reg <= 8'h00;
        if (last) begin
          // Underrun: the pixel path shows transparent until data arrives
          cur_v_reg <= 1'b0;
        end else begin
          pos_reg <= pos_reg + unit[4:0];
        end
      end else begin
        run_reg <= run_reg + 8'h01;
      end
    end
  end
endmodule // gre_pixel_unpack

/* gre_region_engine.v */
// Region display-list graphics engine: list walker, table loader, pixel path and APB registers
//
// The APB interface to the registers and the register addresses were decided locally.
`timescale 1ns/1ps
// Overview of operation
// - Format, size, position and pointers come from the region descriptor.
// - Top and bottom fields use separate bitmaps, direct or compressed.
// - Each region descriptor is 128 bits, fetched whole as four words.
// - List is walked once per field, descriptors in sequence.
// - Host marks last descriptor; walk stops there for this field.
// - Each region uses one bitmap per field plus map and colour tables.
// - Pixels are 2, 4 or 8 bits, direct or run-length, chosen per region.
// - Codes become YUV with 8-bit components plus a transparency factor.
// - Codes pass a map table then the colour_lookup_table.
// - Tables load just before the region, one table set per region.
// - Table load is skipped when the tables are already held locally.
// - Transparency shift replaces per-pixel transparency for the region.
// - Zoom repeats each pixel horizontally.
// - Regions in vertical blanking lines are displayed as well.
// - Blend weight for video mixing comes from the colour table, 64 steps.
// - graphics_box_flag marks every output pixel inside a displayed region.
`include "gre_defines.vh"
module gre_region_engine (
  input wire clk_in, // 100 MHz clock
  input wire srst_in, // Synchronous reset, active high
  input wire [7:0] paddr_in, // APB address
  input wire psel_in, // APB select
  input wire penable_in, // APB enable
  input wire pwrite_in, // APB write
  input wire [31:0] pwdata_in, // APB write data
  output wire [31:0] prdata_out, // APB read data
  output wire pready_out, // APB ready
  output wire pslverr_out, // APB error on unmapped address
  output wire mem_req_out, // Memory read request
  output wire [19:0] mem_addr_out, // Memory word address
  input wire mem_ack_in, // Request accepted
  input wire mem_rvalid_in, // Read data valid
  input wire [31:0] mem_rdata_in, // Read data
  input wire field_start_in, // Field start pulse
  input wire field_bottom_in, // Parity of starting field
  input wire [9:0] line_in, // Current field line
  input wire [9:0] pix_x_in, // Current pixel column
  input wire pix_en_in, // Pixel strobe
  output wire [7:0] gfx_y_out, // Graphics luminance
  output wire [7:0] gfx_u_out, // Graphics U
  output wire [7:0] gfx_v_out, // Graphics V
  output wire [5:0] gfx_t_out, // Graphics blend weight
  output wire graphics_box_flag_out, // Pixel inside a region
  output wire gfx_valid_out // Output pixel strobe
);
  localparam ST_IDLE = 3'd0;
  localparam ST_DESC = 3'd1;
  localparam ST_THDR = 3'd2;
  localparam ST_TMAP = 3'd3;
  localparam ST_TCLUT = 3'd4;
  localparam ST_WAIT = 3'd5;
  localparam ST_ACT = 3'd6;
  localparam ST_DONE = 3'd7;

  reg [2:0] state_reg;
  reg ctrl_en_reg;
  reg [19:0] anchor_reg;
  reg pready_reg;
  reg pslverr_reg;
  reg [31:0] prdata_reg;
  reg mem_req_reg;
  reg outst_reg;
  reg [19:0] mem_addr_reg;
  reg [19:0] fetch_addr_reg;
  reg [19:0] list_ptr_reg;
  reg [31:0] d0_reg;
  reg [31:0] d1_reg;
  reg [31:0] d2_reg;
  reg [31:0] d3_reg;
  reg [1:0] wcnt_reg;
  reg [8:0] idx_reg;
  reg [8:0] colour_lookup_table_cnt_reg;
  reg [6:0] map_cnt_reg;
  reg [19:0] tag_reg;
  reg tag_v_reg;
  reg fs_pend_reg;
  reg fbot_reg;
  reg [7:0] done_cnt_reg;
  reg [31:0] wbuf_reg;
  reg wbuf_v_reg;
  reg ustart_reg;
  reg zph_reg;
  reg p1_pix_reg;
  reg p1_box_reg;
  reg p1_cv_reg;
  reg [1:0] p1_sel_reg;
  reg p2_pix_reg;
  reg p2_box_reg;
  reg p2_cv_reg;
  reg [7:0] y_reg;
  reg [7:0] u_reg;
  reg [7:0] v_reg;
  reg [5:0] t_reg;
  reg box_reg;
  reg valid_reg;

  wire [9:0] xs = d0_reg[`GRE_W0_X];
  wire [9:0] ys = d0_reg[`GRE_W0_Y];
  wire [9:0] wd = d1_reg[`GRE_W1_W];
  wire zoom = d1_reg[`GRE_W1_ZOOM];
  wire [10:0] yend = {1'b0, ys} + {1'b0, d0_reg[`GRE_W0_H]};
  wire [10:0] xend = {1'b0, xs} + (zoom ? {wd, 1'b0} : {1'b0, wd});
  wire [10:0] line11 = {1'b0, line_in};
  wire [10:0] px11 = {1'b0, pix_x_in};
  wire [19:0] tptr = {d3_reg[`GRE_W3_TPH], d2_reg[`GRE_W2_TPL]};
  wire tbl_hit = tag_v_reg && (tag_reg == tptr);
  wire bus_idle = !mem_req_reg && !outst_reg;
  wire got = mem_rvalid_in && outst_reg;
  wire go = fs_pend_reg && ctrl_en_reg && bus_idle;
  wire rlast = (line11 >= yend);
  wire adv_region = ((state_reg == ST_WAIT) && rlast) || ((state_reg == ST_ACT) && rlast && bus_idle);
  wire apb_wr = psel_in && penable_in && pready_reg && pwrite_in;
  wire addr_ok = (paddr_in == `GRE_OFS_CTRL) || (paddr_in == `GRE_OFS_STAT) ||
                 (paddr_in == `GRE_OFS_ANCH) || (paddr_in == `GRE_OFS_TINV);
  reg fetching;
  reg [31:0] rd_mux;

  // Pixel path signals
  wire box = pix_en_in && (state_reg == ST_ACT) && !rlast && (px11 >= {1'b0, xs}) && (px11 < xend);
  wire step = box && (!zoom || zph_reg);
  wire take;
  wire [7:0] code;
  wire code_v;
  wire [31:0] map_q;
  wire [29:0] colour_lookup_table_q;
  wire [7:0] map_byte = map_q[{p1_sel_reg, 3'b000} +: 8];

  assign prdata_out = prdata_reg;
  assign pready_out = pready_reg;
  assign pslverr_out = pslverr_reg;
  assign mem_req_out = mem_req_reg;
  assign mem_addr_out = mem_addr_reg;
  assign gfx_y_out = y_reg;
  assign gfx_u_out = u_reg;
  assign gfx_v_out = v_reg;
  assign gfx_t_out = t_reg;
  assign graphics_box_flag_out = box_reg;
  assign gfx_valid_out = valid_reg;

  always @* begin
    case (state_reg)
      ST_DESC: fetching = 1'b1;
      ST_THDR: fetching = !tbl_hit;
      ST_TMAP: fetching = (idx_reg != {2'b00, map_cnt_reg});
      ST_TCLUT: fetching = (idx_reg != colour_lookup_table_cnt_reg);
      ST_ACT: fetching = !wbuf_v_reg && !rlast;
      default: fetching = 1'b0;
    endcase
  end

  always @* begin
    case (paddr_in)
      `GRE_OFS_CTRL: rd_mux = {31'h0, ctrl_en_reg};
      `GRE_OFS_STAT: rd_mux = {16'h0, done_cnt_reg, 2'b00, fbot_reg, fs_pend_reg, tag_v_reg, state_reg};
      `GRE_OFS_ANCH: rd_mux = {12'h000, anchor_reg};
      default: rd_mux = 32'h00000000;
    endcase
  end

  // APB slave: answers in the first access cycle, unmapped addresses raise pslverr
  always @(posedge clk_in) begin
    if (srst_in) begin
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg <= 32'h00000000;
      ctrl_en_reg <= `GRE_CTRL_RST;
      anchor_reg <= `GRE_ANCH_RST;
    end else begin
      pready_reg <= psel_in && !penable_in;
      pslverr_reg <= psel_in && !penable_in && !addr_ok;
      if (psel_in && !penable_in) begin
        prdata_reg <= rd_mux;
      end
      if (apb_wr && (paddr_in == `GRE_OFS_CTRL)) begin
        ctrl_en_reg <= pwdata_in[0];
      end
      if (apb_wr && (paddr_in == `GRE_OFS_ANCH)) begin
        anchor_reg <= pwdata_in[19:0];
      end
    end
  end

  // List walker, table loader and memory read port; one read outstanding at a time
  always @(posedge clk_in) begin
    if (srst_in) begin
      state_reg <= ST_IDLE;
      mem_req_reg <= 1'b0;
      outst_reg <= 1'b0;
      mem_addr_reg <= 20'h00000;
      fetch_addr_reg <= 20'h00000;
      list_ptr_reg <= 20'h00000;
      d0_reg <= 32'h00000000;
      d1_reg <= 32'h00000000;
      d2_reg <= 32'h00000000;
      d3_reg <= 32'h00000000;
      wcnt_reg <= 2'b00;
      idx_reg <= 9'h000;
      colour_lookup_table_cnt_reg <= 9'h000;
      map_cnt_reg <= 7'h00;
      tag_reg <= 20'h00000;
      tag_v_reg <= 1'b0;
      fs_pend_reg <= 1'b0;
      fbot_reg <= 1'b0;
      done_cnt_reg <= 8'h00;
      wbuf_reg <= 32'h00000000;
      wbuf_v_reg <= 1'b0;
      ustart_reg <= 1'b0;
    end else begin
      fs_pend_reg <= field_start_in || (fs_pend_reg && !go);
      if (field_start_in) begin
        fbot_reg <= field_bottom_in;
      end
      ustart_reg <= 1'b0;
      if (fetching && bus_idle) begin
        mem_req_reg <= 1'b1;
        mem_addr_reg <= fetch_addr_reg;
      end else if (mem_req_reg && mem_ack_in) begin
        mem_req_reg <= 1'b0;
        outst_reg <= 1'b1;
        fetch_addr_reg <= fetch_addr_reg + 20'h00001;
      end
      if (got) begin
        outst_reg <= 1'b0;
      end
      if (apb_wr && (paddr_in == `GRE_OFS_TINV)) begin
        tag_v_reg <= 1'b0;
      end
      if (take) begin
        wbuf_v_reg <= 1'b0;
      end
      if (go) begin
        state_reg <= ST_DESC;
        fetch_addr_reg <= anchor_reg;
        wcnt_reg <= 2'b00;
        done_cnt_reg <= 8'h00;
      end else if (!ctrl_en_reg && bus_idle) begin
        state_reg <= ST_IDLE;
      end else begin
        case (state_reg)
          ST_DESC: begin
            if (got) begin
              wcnt_reg <= wcnt_reg + 2'b01;
              case (wcnt_reg)
                2'd0: d0_reg <= mem_rdata_in;
                2'd1: d1_reg <= mem_rdata_in;
                2'd2: d2_reg <= mem_rdata_in;
                default: d3_reg <= mem_rdata_in;
              endcase
              if (wcnt_reg == `GRE_DESC_LAST) begin
                list_ptr_reg <= fetch_addr_reg;
                fetch_addr_reg <= {mem_rdata_in[`GRE_W3_TPH], d2_reg[`GRE_W2_TPL]};
                state_reg <= ST_THDR;
              end
            end
          end
          ST_THDR: begin
            if (tbl_hit) begin
              state_reg <= ST_WAIT;
            end else if (got) begin
              colour_lookup_table_cnt_reg <= mem_rdata_in[`GRE_TH_COLOUR_LOOKUP_TABLE];
              map_cnt_reg <= mem_rdata_in[`GRE_TH_MAP];
              idx_reg <= 9'h000;
              tag_v_reg <= 1'b0;
              state_reg <= ST_TMAP;
            end
          end
          ST_TMAP: begin
            if (idx_reg == {2'b00, map_cnt_reg}) begin
              idx_reg <= 9'h000;
              state_reg <= ST_TCLUT;
            end else if (got) begin
              idx_reg <= idx_reg + 9'h001;
            end
          end
          ST_TCLUT: begin
            if (idx_reg == colour_lookup_table_cnt_reg) begin
              tag_reg <= tptr;
              tag_v_reg <= 1'b1;
              state_reg <= ST_WAIT;
            end else if (got) begin
              idx_reg <= idx_reg + 9'h001;
            end
          end
          ST_WAIT: begin
            // Bitmap choice per field; blanking lines are no different from active ones
            fetch_addr_reg <= fbot_reg ? d3_reg[`GRE_W3_BOT] : d2_reg[`GRE_W2_TOP];
            wbuf_v_reg <= 1'b0;
            if (!rlast && (line11 >= {1'b0, ys})) begin
              state_reg <= ST_ACT;
              ustart_reg <= 1'b1;
            end
          end
          ST_ACT: begin
            if (got) begin
              wbuf_reg <= mem_rdata_in;
              wbuf_v_reg <= 1'b1;
            end
          end
          default: begin
          end
        endcase
        if (adv_region) begin
          done_cnt_reg <= done_cnt_reg + 8'h01;
          if (d0_reg[`GRE_W0_EOL]) begin
            state_reg <= ST_DONE;
          end else begin
            state_reg <= ST_DESC;
            fetch_addr_reg <= list_ptr_reg;
            wcnt_reg <= 2'b00;
          end
        end
      end
    end
  end

  gre_pixel_unpack u_unpack (
    .clk_in(clk_in),
    .srst_in(srst_in),
    .start_in(ustart_reg),
    .depth_in(d1_reg[`GRE_W1_DEPTH]),
    .coded_in(d1_reg[`GRE_W1_CODED]),
    .word_in(wbuf_reg),
    .word_valid_in(wbuf_v_reg),
    .step_in(step),
    .word_take_out(take),
    .code_out(code),
    .code_valid_out(code_v)
  );

  // Map table: four 8-bit entries per word, indexed by pixel code
  gre_table_ram #(.AW(6), .DW(32)) u_map (
    .clk_in(clk_in),
    .srst_in(srst_in),
    .we_in(got && (state_reg == ST_TMAP)),
    .waddr_in(idx_reg[5:0]),
    .wdata_in(mem_rdata_in),
    .raddr_in(code[7:2]),
    .rdata_out(map_q)
  );

  gre_table_ram #(.AW(8), .DW(30)) u_colour_lookup_table (
    .clk_in(clk_in),
    .srst_in(srst_in),
    .we_in(got && (state_reg == ST_TCLUT)),
    .waddr_in(idx_reg[7:0]),
    .wdata_in(mem_rdata_in[29:0]),
    .raddr_in(map_byte),
    .rdata_out(colour_lookup_table_q)
  );

  // Three-stage pixel pipeline: map read, colour read, output register
  always @(posedge clk_in) begin
    if (srst_in) begin
      zph_reg <= 1'b0;
      p1_pix_reg <= 1'b0;
      p1_box_reg <= 1'b0;
      p1_cv_reg <= 1'b0;
      p1_sel_reg <= 2'b00;
      p2_pix_reg <= 1'b0;
      p2_box_reg <= 1'b0;
      p2_cv_reg <= 1'b0;
      y_reg <= `GRE_IDLE_Y;
      u_reg <= `GRE_IDLE_C;
      v_reg <= `GRE_IDLE_C;
      t_reg <= 6'h00;
      box_reg <= 1'b0;
      valid_reg <= 1'b0;
    end else begin
      zph_reg <= box ? !zph_reg : 1'b0;
      p1_pix_reg <= pix_en_in;
      p1_box_reg <= box;
      p1_cv_reg <= code_v;
      p1_sel_reg <= code[1:0];
      p2_pix_reg <= p1_pix_reg;
      p2_box_reg <= p1_box_reg;
      p2_cv_reg <= p1_cv_reg;
      valid_reg <= p2_pix_reg;
      box_reg <= p2_box_reg;
      if (p2_box_reg && p2_cv_reg) begin
        y_reg <= colour_lookup_table_q[`GRE_CL_Y];
        u_reg <= colour_lookup_table_q[`GRE_CL_U];
        v_reg <= colour_lookup_table_q[`GRE_CL_V];
        t_reg <= d1_reg[`GRE_W1_TSEN] ? d1_reg[`GRE_W1_TSV] : colour_lookup_table_q[`GRE_CL_T];
      end else begin
        // Starved or outside a region: let the video through untouched
        y_reg <= `GRE_IDLE_Y;
        u_reg <= `GRE_IDLE_C;
        v_reg <= `GRE_IDLE_C;
        t_reg <= 6'h00;
      end
    end
  end
endmodule // gre_region_engine

/* gre_region_engine_checker.sv */
// Port-level assertions for the region graphics engine
`timescale 1ns/1ps
`include "gre_defines.vh"
module gre_region_engine_checker (
  input wire clk_in, // Clock
  input wire srst_in, // Reset
  input wire [7:0] paddr_in, // APB address
  input wire psel_in, // APB select
  input wire penable_in, // APB enable
  input wire pwrite_in, // APB write
  input wire [31:0] prdata_out, // APB read data
  input wire pready_out, // APB ready
  input wire pslverr_out, // APB error
  input wire mem_req_out, // Read request
  input wire [19:0] mem_addr_out, // Word address
  input wire mem_ack_in, // Request taken
  input wire mem_rvalid_in, // Data valid
  input wire pix_en_in, // Pixel strobe
  input wire [5:0] gfx_t_out, // Blend weight
  input wire [7:0] gfx_y_out, // Luminance
  input wire graphics_box_flag_out, // Inside region
  input wire gfx_valid_out // Pixel out strobe
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (srst_in);
  reg wait_reg;
  // Marks the single read in flight between accept and data
  always @(posedge clk_in) begin
    if (srst_in || mem_rvalid_in) wait_reg <= 1'b0;
    else if (mem_req_out && mem_ack_in) wait_reg <= 1'b1;
  end
  sequence s_setup; psel_in && !penable_in; endsequence
  sequence s_done; psel_in && penable_in && pready_out; endsequence
  sequence s_rd; s_done ##0 !pwrite_in; endsequence
  a_apb_zero_wait: assert property (s_setup |=> s_done) else $error("setup not answered next cycle");
  a_ready_single: assert property (s_done |=> !pready_out) else $error("pready longer than one cycle");
  a_err_ready: assert property (pslverr_out |-> pready_out) else $error("pslverr without pready");
  a_err_reads_zero: assert property (s_rd ##0 pslverr_out |-> prdata_out == 32'h0) else $error("bad read data");
  a_tinv_zero: assert property (s_rd ##0 paddr_in == `GRE_OFS_TINV |-> prdata_out == 32'h0 && !pslverr_out)
    else $error("invalidate register read wrong");
  a_req_held: assert property (mem_req_out && !mem_ack_in |=> mem_req_out && $stable(mem_addr_out))
    else $error("request dropped or moved");
  a_one_read: assert property (wait_reg |-> !mem_req_out) else $error("second read in flight");
  a_pixel_latency: assert property (pix_en_in |-> ##3 gfx_valid_out) else $error("pixel late");
  a_no_stray_pixel: assert property (!pix_en_in |-> ##3 !gfx_valid_out) else $error("stray pixel");
  a_outside_clear: assert property (gfx_valid_out && !graphics_box_flag_out |-> gfx_t_out == 6'h0 &&
    gfx_y_out == `GRE_IDLE_Y) else $error("outside pixel not transparent");
  a_reset_quiet: assert property (disable iff (1'b0) srst_in |=> !pready_out && !mem_req_out && !gfx_valid_out)
    else $error("outputs active after reset");
endmodule // gre_region_engine_checker
bind gre_region_engine gre_region_engine_checker chk_u (.clk_in(clk_in), .srst_in(srst_in), .paddr_in(paddr_in),
  .psel_in(psel_in), .penable_in(penable_in), .pwrite_in(pwrite_in), .prdata_out(prdata_out),
  .pready_out(pready_out), .pslverr_out(pslverr_out), .mem_req_out(mem_req_out), .mem_addr_out(mem_addr_out),
  .mem_ack_in(mem_ack_in), .mem_rvalid_in(mem_rvalid_in), .pix_en_in(pix_en_in), .gfx_t_out(gfx_t_out),
  .gfx_y_out(gfx_y_out), .graphics_box_flag_out(graphics_box_flag_out), .gfx_valid_out(gfx_valid_out));

/* gre_region_engine_tb.sv */
// Self-checking bench for the region graphics engine
`timescale 1ns/1ps
`include "gre_defines.vh"
module gre_region_engine_tb;
  localparam int ANC = 4, TBL = 256, BMP = 768, XS = 8, YS = 5;
  logic clk_in = 0, srst = 1, psel = 0, penable = 0, pwrite = 0, fstart = 0, fbot = 0, pix_en = 0, slow = 0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, rd;
  logic [9:0] line = 10'h0, px = 10'h0;
  wire [31:0] prdata, rdat;
  wire [19:0] maddr;
  wire [7:0] gy, gu, gv;
  wire [5:0] gt;
  wire pready, perr, mreq, ack, rv, box, gval;
  logic [64:0] aq[$];
  logic [30:0] pq[$];
  logic [31:0] bm[4];
  int n_mismatch = 0, check_count = 0, n_tbl = 0, n_anc = 0, n_eol = 0, dep, cod, zm, ts, t0;
  always #5 clk_in = ~clk_in;
  gre_region_engine dut_u (.clk_in(clk_in), .srst_in(srst), .paddr_in(paddr), .psel_in(psel), .penable_in(penable),
    .pwrite_in(pwrite), .pwdata_in(pwdata), .prdata_out(prdata), .pready_out(pready), .pslverr_out(perr),
    .mem_req_out(mreq), .mem_addr_out(maddr), .mem_ack_in(ack), .mem_rvalid_in(rv), .mem_rdata_in(rdat),
    .field_start_in(fstart), .field_bottom_in(fbot), .line_in(line), .pix_x_in(px), .pix_en_in(pix_en),
    .gfx_y_out(gy), .gfx_u_out(gu), .gfx_v_out(gv), .gfx_t_out(gt), .graphics_box_flag_out(box),
    .gfx_valid_out(gval));
  gre_mem_model mem_u (.clk_in(clk_in), .srst_in(srst), .mem_req_in(mreq), .mem_addr_in(maddr), .slow_in(slow),
    .mem_ack_out(ack), .mem_rvalid_out(rv), .mem_rdata_out(rdat));
  task check(input logic [63:0] seen, input logic [63:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: saw %h wanted %h", $time, seen, exp);
    end
  endtask
  task wrap_up;
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task apb(input bit w, input logic [7:0] a, input logic [31:0] d, e, mk, input bit er);
    aq.push_back({er, mk, e});
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_in);
    penable <= 1'b1;
    do @(posedge clk_in); while (pready !== 1'b1);
    rd = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk_in);
  endtask
  function automatic logic [7:0] code_at(int i);
    int b;
    b = 2 << dep;
    if (cod) return bm[i / 4][(i / 2 % 2) * 16 +: 8];
    return 8'(bm[i * b / 32] >> (i * b % 32)) & 8'((1 << b) - 1);
  endfunction
  function automatic logic [30:0] px_exp(int x, bit on);
    logic [7:0] m;
    if (!on || x < XS || x >= XS + (8 << zm)) return {1'b0, 6'h0, `GRE_IDLE_Y, `GRE_IDLE_C, `GRE_IDLE_C};
    m = code_at((x - XS) >> zm) ^ 8'h5a;
    return {1'b1, ts ? 6'h2a : m[5:0], m, m ^ 8'h33, ~m};
  endfunction
  task pixels(input int n, input bit on);
    for (int x = 0; x < n; x++) begin
      px <= 10'(x);
      pix_en <= 1'b1;
      pq.push_back(px_exp(x, on));
      @(posedge clk_in);
    end
    pix_en <= 1'b0;
    for (int k = 0; k < 50 && pq.size() > 0; k++) @(posedge clk_in);
  endtask
  always @(posedge clk_in) begin
    if (psel && penable && pready && aq.size() > 0) begin
      logic [64:0] e;
      e = aq.pop_front();
      check({perr, prdata & e[63:32]}, {e[64], e[31:0] & e[63:32]});
    end
    if (gval) check({box, gt, gy, gu, gv},
      pq.size() ? pq.pop_front() : 'x);
    if (mreq && ack) begin
      n_tbl += (maddr == TBL);
      n_anc += (maddr == ANC);
      n_eol += (maddr == ANC + 4);
    end
  end
  initial begin
    repeat (60000) @(posedge clk_in);
    n_mismatch++;
    $display("unexpected at %0t: run did not finish", $time);
    wrap_up;
  end
  initial begin
    void'($urandom(32'ha8f130a0));
    // Shared table: map byte is code xor 5a, colour entry derived from its index
    mem_u.mem[TBL] = {16'h0, 7'd64, 9'd256};
    for (int k = 0; k < 64; k++) mem_u.mem[TBL + 1 + k] = {8'(4*k+3), 8'(4*k+2), 8'(4*k+1), 8'(4*k)} ^ 32'h5a5a5a5a;
    for (int k = 0; k < 256; k++) mem_u.mem[TBL + 65 + k] = {2'b00, 6'(k), ~8'(k), 8'(k) ^ 8'h33, 8'(k)};
    mem_u.mem[ANC + 4] = 32'hffffffff;
    repeat (4) @(posedge clk_in);
    srst <= 1'b0;
    apb(0, `GRE_OFS_CTRL, 0, 0, '1, 0);
    apb(0, `GRE_OFS_ANCH, 0, 0, '1, 0);
    apb(1, 8'h10, 32'h1, 0, 0, 1);
    apb(0, 8'h10, 0, 0, '1, 1);
    apb(0, `GRE_OFS_TINV, 0, 0, '1, 0);
    apb(1, `GRE_OFS_ANCH, ANC, 0, 0, 0);
    apb(0, `GRE_OFS_ANCH, 0, ANC, '1, 0);
    apb(1, `GRE_OFS_CTRL, 1, 0, 0, 0);
    for (int m = 0; m < 4; m++) begin
      dep = (m < 3) ? m : 2;
      cod = (m == 3);
      zm = (m == 3);
      ts = (m == 2);
      for (int w = 0; w < 4; w++) begin
        bm[w] = cod ? ($urandom & 32'h00ff00ff) | 32'h02000200 : $urandom;
        mem_u.mem[BMP + w] = bm[w];
      end
      mem_u.mem[ANC] = {1'b1, 1'b0, 10'd1, 10'(YS), 10'(XS)};
      mem_u.mem[ANC + 1] = {11'h0, 6'h2a, 1'(ts), 1'(zm), 1'(cod), 2'(dep), 10'd8};
      // Bottom fields get a top pointer at unwritten words, so a wrong field choice shows up
      mem_u.mem[ANC + 2] = {12'(TBL), 20'(BMP + 16 * m[0])};
      mem_u.mem[ANC + 3] = {4'h0, 8'(TBL >> 12), 20'(BMP)};
      if (m == 2) apb(1, `GRE_OFS_TINV, 0, 0, 0, 0);
      t0 = n_tbl;
      slow <= 1'b1;
      fbot <= m[0];
      fstart <= 1'b1;
      line <= 10'h0;
      @(posedge clk_in);
      fstart <= 1'b0;
      rd = 0;
      for (int k = 0; k < 4000 && rd[2:0] != 3'd5; k++) apb(0, `GRE_OFS_STAT, 0, 0, 0, 0);
      apb(0, `GRE_OFS_STAT, 0, {26'h0, 1'(m[0]), 5'h0d}, 32'hff2f, 0);
      check(n_tbl - t0, (m == 0 || m == 2));
      check(n_anc, m + 1);
      slow <= 1'b0;
      line <= 10'(YS);
      pixels(32, 1);
      line <= 10'(YS + 1);
      pixels(24, 0);
      $display("field %0d done", m);
    end
    check(n_eol, 0);
    wrap_up;
  end
endmodule // gre_region_engine_tb

/* gre_table_ram.v */
// Local table memory with registered read data
`timescale 1ns/1ps
module gre_table_ram #(
  parameter AW = 8,
  parameter DW = 32
) (
  input wire clk_in, // Clock
  input wire srst_in, // Synchronous reset
  input wire we_in, // Write strobe
  input wire [AW-1:0] waddr_in, // Write address
  input wire [DW-1:0] wdata_in, // Write data
  input wire [AW-1:0] raddr_in, // Read address
  output reg [DW-1:0] rdata_out // Read data, one cycle after address
);
  reg [DW-1:0] mem [0:(1<<AW)-1];

  always @(posedge clk_in) begin
    if (we_in) begin
      mem[waddr_in] <= wdata_in;
    end
    if (srst_in) begin
      rdata_out <= {DW{1'b0}};
    end else begin
      rdata_out <= mem[raddr_in];
    end
  end
endmodule // gre_table_ram
